// ---- test_watchdog_and_reset_flags.sv ----
// self-checking bench for the watchdog and reset-flag block
// assumes the core model drives core events; slow oscillator made here
`timescale 1ns/1ps
`include "wdt_map.svh"
module test_watchdog_and_reset_flags
  import wdt_pkg::*;
;
  logic clk_sys = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0, rd_dp = 1'h0;
  logic slow_osc = 1'h0, low_supply = 1'h0, kick_en = 1'h0, ce = 1'h1, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [15:0] kick_gap = 16'h0190;
  logic [7:0] port_data, port_dir;
  core_event_type core_event;
  reset_out_type reset_out;
  logic [63:0] q[$];
  int n_fail = 0, cmp_count = 0, c;

  always #12.5 clk_sys = ~clk_sys;
  always #50 slow_osc = ~slow_osc;

  watchdog_and_reset_flags #(.BROWNOUT_QUALIFY_CYCLES(8)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(`HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .slow_internal_osc(slow_osc), .low_supply(low_supply),
    .core_event(core_event), .reset_out(reset_out), .port_data(port_data), .port_dir(port_dir));
  wdt_core_model u_core (.clk_sys(clk_sys), .rstn(rstn), .kick_en(kick_en), .kick_gap(kick_gap),
    .reset_out(reset_out), .core_event(core_event));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic edge_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hreadyout !== 1'h1 && n < 20);
    if (hreadyout !== 1'h1)
    begin
      n_fail++;
      wrap_up();
    end
  endtask : edge_ready

  // single word transfer; on reads d is the expected value under mask m
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 0);
    hsel <= 1'h1;
    htrans <= `HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    edge_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !wr;
    if (!wr)
      q.push_back({m, d});
    edge_ready();
    rd_dp <= 1'h0;
  endtask : bus

  // sampled at falling edges, returns on a rising edge
  task automatic wait_pulse(input logic full, input int lim);
    c = 0;
    do
    begin
      @(negedge clk_sys);
      c++;
    end
    while ((full ? reset_out.device_reset : reset_out.pc_sp_clear) !== 1'h1 && c < lim);
    @(posedge clk_sys);
  endtask : wait_pulse

  always @(posedge clk_sys)
    if (rd_dp && q.size() > 0)
    begin
      logic [63:0] e;
      e = q.pop_front();
      check("read data", hrdata & e[63:32], e[31:0]);
    end

  initial
  begin
    logic [4:0] k;
    int e;
    void'($urandom(7196));
    repeat (6) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    bus(0, `CTRL_ADDR, 32'h53, 32'hffffffff);
    bus(0, `CAUSE_ADDR, 32'h0, 32'hff);
    bus(0, `STATUS_ADDR, 32'h0, 32'h3);
    bus(1, `CTRL_ADDR, {24'($urandom), 8'hab});
    wait_pulse(1, 100);
    check("valid key", c, 100);
    do k = 5'($urandom); while (k == `KEY_PATTERN_A || k == `KEY_PATTERN_B);
    bus(1, `CTRL_ADDR, {24'h0, k, 3'h0});
    ce <= 1'h0;
    wait_pulse(1, 50);
    check("frozen by enable", c, 50);
    ce <= 1'h1;
    wait_pulse(1, 60);
    check("key delay", c > 38 && c < 46, 1);
    bus(0, `CTRL_ADDR, 32'h53, 32'hff);
    bus(0, `CAUSE_ADDR, 32'h1, 32'hff);
    bus(1, `CAUSE_ADDR, 32'h0);
    bus(0, `CAUSE_ADDR, 32'h0, 32'hff);
    bus(1, `CAUSE_ADDR, 32'h5);
    bus(0, `CAUSE_ADDR, 32'h0, 32'hff);
    for (int s = 0; s < 3; s++)
    begin
      e = 4 << (8 + 2 * s);
      bus(1, `CTRL_ADDR, {24'h0, 5'h0a, 3'(s)});
      u_core.pulse(1'h0);
      wait_pulse(1, 20000);
      check("period", c > e - 12 && c < e + 12, 1);
      bus(0, `STATUS_ADDR, 32'h1, 32'h1);
    end
    bus(1, `CTRL_ADDR, 32'h50);
    kick_en <= 1'h1;
    wait_pulse(1, 3000);
    check("kicked", c, 3000);
    kick_en <= 1'h0;
    u_core.pulse(1'h1);
    bus(0, `STATUS_ADDR, 32'h6, 32'h7);
    low_supply <= 1'h1;
    wait_pulse(1, 40);
    check("asleep low supply", c, 40);
    low_supply <= 1'h0;
    wait_pulse(0, 1200);
    check("sleep overflow", {c < 1200, reset_out.device_reset}, 2'h2);
    bus(0, `STATUS_ADDR, 32'h3, 32'h3);
    low_supply <= 1'h1;
    repeat (5) @(posedge clk_sys);
    low_supply <= 1'h0;
    wait_pulse(1, 30);
    check("short low supply", c, 30);
    low_supply <= 1'h1;
    wait_pulse(1, 30);
    check("brownout", c < 30, 1);
    low_supply <= 1'h0;
    bus(0, `CAUSE_ADDR, 32'h4, 32'h4);
    bus(0, `STATUS_ADDR, 32'h3, 32'h3);
    wrap_up();
  end
endmodule : test_watchdog_and_reset_flags

// ---- watchdog_and_reset_flags.sv ----
// watchdog timer with keyed enable, period select and reset-cause flags
// assumes: core events arrive on clk_sys; slow oscillator and low-supply
// indication are pins, synchronised here; rstn is the power-on reset
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "wdt_map.svh"

module watchdog_and_reset_flags
  import wdt_pkg::*;
#(
  parameter int PORT_WIDTH = 8,
  parameter int BROWNOUT_QUALIFY_CYCLES =
    (`BROWNOUT_QUALIFY_NS * `CLK_MHZ + 999) / 1000
)
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // pins
  input wire logic slow_internal_osc,
  input wire logic low_supply,
  // cpu core
  input core_event_type core_event,
  output reset_out_type reset_out,
  output logic [PORT_WIDTH-1:0] port_data,
  output logic [PORT_WIDTH-1:0] port_dir
);

  localparam int KEY_DELAY_CYCLES =
    (`KEY_RESET_DELAY_NS * `CLK_MHZ + 999) / 1000;
  localparam int CW = `WDT_COUNT_WIDTH;
  localparam int BW = $clog2(BROWNOUT_QUALIFY_CYCLES + 1);
  localparam int KW = $clog2(KEY_DELAY_CYCLES + 1);

  logic [1:0] osc_sync;
  logic [1:0] low_sync;
  logic osc_prev;
  logic [1:0] next_osc_sync;
  logic [1:0] next_low_sync;
  logic next_osc_prev;
  logic slow_tick;
  always_comb
  begin
    next_osc_sync = {osc_sync[0], slow_internal_osc};
    next_low_sync = {low_sync[0], low_supply};
    next_osc_prev = osc_sync[1];
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_sync <= 2'h0;
      low_sync <= 2'h0;
      osc_prev <= 1'b0;
    end
    else if (ce)
    begin
      osc_sync <= next_osc_sync;
      low_sync <= next_low_sync;
      osc_prev <= next_osc_prev;
    end
  end
  // one tick per slow oscillator rising edge
  assign slow_tick = osc_sync[1] & ~osc_prev;

  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] next_hrdata;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic addr_phase;
  logic [7:0] ctrl;
  logic key_flag;
  logic brown_flag;
  logic timeout_flag;
  logic powerdown_flag;
  key_state_type key_state;
  assign hreadyout = 1'h1;
  assign hresp = `HRESP_OKAY;
  assign addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ);

  always_comb
  begin
    next_wr_pend = addr_phase & hwrite & (hsize == `HSIZE_WORD);
    next_wr_addr = haddr[`ADDR_LSB_MSB:0];
    next_hrdata = hrdata;
    if (addr_phase && !hwrite)
    begin
      next_hrdata = 32'h0;
      case (haddr[`ADDR_LSB_MSB:0])
        `CTRL_ADDR: next_hrdata[7:0] = ctrl;
        `CAUSE_ADDR:
        begin
          next_hrdata[`KEY_FLAG_BIT] = key_flag;
          next_hrdata[`BROWN_FLAG_BIT] = brown_flag;
        end
        `STATUS_ADDR:
        begin
          next_hrdata[`TIMEOUT_BIT] = timeout_flag;
          next_hrdata[`POWERDOWN_BIT] = powerdown_flag;
          next_hrdata[`SLEEP_BIT] = core_event.sleep_idle;
          next_hrdata[`KEY_WAIT_BIT] = key_state;
        end
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
      hrdata <= 32'h0;
    end
    else if (ce)
    begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  logic ctrl_wr;
  logic cause_wr;
  assign ctrl_wr = wr_pend & (wr_addr == `CTRL_ADDR);
  assign cause_wr = wr_pend & (wr_addr == `CAUSE_ADDR);
  logic [4:0] key;
  logic key_valid;
  logic [KW-1:0] key_cnt;
  logic [BW-1:0] brown_cnt;
  logic brown_armed;
  logic [CW-1:0] wdt_cnt;
  logic [CW-1:0] period_mask;
  logic overflow;
  logic key_fire;
  logic brown_fire;
  logic wdt_full;
  logic full_reset;
  key_state_type next_key_state;
  logic [KW-1:0] next_key_cnt;
  logic [BW-1:0] next_brown_cnt;
  logic next_brown_armed;
  logic [CW-1:0] next_wdt_cnt;
  assign key = ctrl[`KEY_MSB:`KEY_LSB];
  assign key_valid = (key == `KEY_PATTERN_A) || (key == `KEY_PATTERN_B);

  // division ratio per period select
  always_comb
  begin
    case (ctrl[`SEL_MSB:`SEL_LSB])
      3'h0: period_mask = CW'((1 << `PERIOD_EXP_0) - 1);
      3'h1: period_mask = CW'((1 << `PERIOD_EXP_1) - 1);
      3'h2: period_mask = CW'((1 << `PERIOD_EXP_2) - 1);
      3'h3: period_mask = CW'((1 << `PERIOD_EXP_3) - 1);
      3'h4: period_mask = CW'((1 << `PERIOD_EXP_4) - 1);
      3'h5: period_mask = CW'((1 << `PERIOD_EXP_5) - 1);
      3'h6: period_mask = CW'((1 << `PERIOD_EXP_6) - 1);
      3'h7: period_mask = CW'((1 << `PERIOD_EXP_7) - 1);
      default: period_mask = CW'((1 << `PERIOD_EXP_7) - 1);
    endcase
  end

  // last slow tick before the selected bit rolls over
  assign overflow = key_valid && slow_tick && ((wdt_cnt & period_mask) == period_mask);
  assign key_fire = (key_state == KEY_WAIT) && (key_cnt == KW'(KEY_DELAY_CYCLES - 1));
  assign brown_fire = brown_armed && low_sync[1] && !core_event.sleep_idle
    && (brown_cnt == BW'(BROWNOUT_QUALIFY_CYCLES - 1));
  assign wdt_full = overflow && !core_event.sleep_idle;
  assign full_reset = key_fire || brown_fire || wdt_full;
  always_comb
  begin
    next_key_state = key_state;
    next_key_cnt = key_cnt;
    case (key_state)
      KEY_OK:
      begin
        next_key_cnt = '0;
        if (!key_valid)
          next_key_state = KEY_WAIT;
      end
      KEY_WAIT:
      begin
        next_key_cnt = key_cnt + 1'b1;
        if (key_fire || full_reset)
          next_key_state = KEY_OK;
      end
      default: next_key_state = KEY_OK;
    endcase
    // low supply must persist; shorter dips restart the count
    next_brown_cnt = '0;
    next_brown_armed = brown_armed;
    if (!low_sync[1])
      next_brown_armed = 1'b1;
    else if (brown_fire)
      next_brown_armed = 1'b0;
    if (low_sync[1] && brown_armed && !core_event.sleep_idle && !brown_fire)
      next_brown_cnt = brown_cnt + 1'h1;
    next_wdt_cnt = wdt_cnt;
    if (slow_tick)
      next_wdt_cnt = wdt_cnt + 1'b1;
    if (!key_valid || core_event.clear_instr || core_event.halt_instr || full_reset || overflow)
      next_wdt_cnt = '0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      key_state <= KEY_OK;
      key_cnt <= '0;
      brown_cnt <= '0;
      brown_armed <= 1'b1;
      wdt_cnt <= '0;
    end
    else if (ce)
    begin
      key_state <= next_key_state;
      key_cnt <= next_key_cnt;
      brown_cnt <= next_brown_cnt;
      brown_armed <= next_brown_armed;
      wdt_cnt <= next_wdt_cnt;
    end
  end

  logic [7:0] next_ctrl;
  logic next_key_flag;
  logic next_brown_flag;
  logic next_timeout_flag;
  logic next_powerdown_flag;
  reset_out_type next_reset_out;
  logic [PORT_WIDTH-1:0] next_port_data;
  logic [PORT_WIDTH-1:0] next_port_dir;
  always_comb
  begin
    next_ctrl = ctrl;
    if (ctrl_wr)
      next_ctrl = hwdata[7:0];
    if (full_reset)
      next_ctrl = `CTRL_RESET;
    // firmware can only clear; a same-cycle hardware set wins
    next_key_flag = key_flag;
    next_brown_flag = brown_flag;
    if (cause_wr)
    begin
      next_key_flag = key_flag & hwdata[`KEY_FLAG_BIT];
      next_brown_flag = brown_flag & hwdata[`BROWN_FLAG_BIT];
    end
    if (key_fire)
      next_key_flag = 1'b1;
    if (brown_fire)
      next_brown_flag = 1'h1;
    next_timeout_flag = timeout_flag;
    next_powerdown_flag = powerdown_flag;
    if (core_event.clear_instr)
      next_powerdown_flag = 1'b0;
    if (core_event.halt_instr)
    begin
      next_powerdown_flag = 1'b1;
      next_timeout_flag = 1'b0;
    end
    if (overflow)
      next_timeout_flag = 1'h1;
    next_reset_out.device_reset = full_reset;
    next_reset_out.pc_sp_clear = full_reset || overflow;
    next_port_data = port_data;
    next_port_dir = port_dir;
    if (full_reset)
    begin
      next_port_data = '1;
      next_port_dir = '1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= `CTRL_RESET;
      key_flag <= 1'b0;
      brown_flag <= 1'b0;
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      reset_out <= '{device_reset: 1'b1, pc_sp_clear: 1'b1};
      port_data <= '1;
      port_dir <= '1;
    end
    else if (ce)
    begin
      ctrl <= next_ctrl;
      key_flag <= next_key_flag;
      brown_flag <= next_brown_flag;
      timeout_flag <= next_timeout_flag;
      powerdown_flag <= next_powerdown_flag;
      reset_out <= next_reset_out;
      port_data <= next_port_data;
      port_dir <= next_port_dir;
    end
  end

endmodule : watchdog_and_reset_flags

// ---- watchdog_and_reset_flags_asserts.sv ----
// checker for the watchdog block, bound to its top module
// assumes one domain: clk_sys with active-low rstn
`timescale 1ns/1ps
`include "wdt_map.svh"
module wdt_flags_asserts
  import wdt_pkg::*;
#(
  parameter int PORT_WIDTH = 8
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bus
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // core side
  input core_event_type core_event,
  input reset_out_type reset_out,
  input wire logic [PORT_WIDTH-1:0] port_data,
  input wire logic [PORT_WIDTH-1:0] port_dir
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_rd_cause;
    ce && hsel && hready && htrans == `HTRANS_NONSEQ && !hwrite && haddr[7:0] == `CAUSE_ADDR;
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_full_clears_pc: assert property (reset_out.device_reset |-> reset_out.pc_sp_clear)
    else $error("full reset without pc clear");
  a_full_ports_ones: assert property (reset_out.device_reset |=> &port_data && &port_dir)
    else $error("ports not all ones after reset");
  a_full_one_cycle: assert property (reset_out.device_reset |=> !reset_out.device_reset)
    else $error("device reset longer than a cycle");
  a_pcsp_one_cycle: assert property ($rose(reset_out.pc_sp_clear) |=> $fell(reset_out.pc_sp_clear))
    else $error("pc clear longer than a cycle");
  a_sleep_pc_only: assert property (reset_out.pc_sp_clear && !reset_out.device_reset |->
    $past(core_event.sleep_idle) || $past(core_event.sleep_idle, 2)) else $error("pc clear while awake");
  a_sleep_no_full: assert property (core_event.sleep_idle [*3] |-> !reset_out.device_reset)
    else $error("full reset while asleep");
  a_cause_unused: assert property (s_rd_cause |=> hrdata[7:3] == 5'h00 && !hrdata[1])
    else $error("unused cause bits set");

  a_rdata_holds: assert property (!(hsel && hready && htrans == `HTRANS_NONSEQ && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  c_full: cover property (reset_out.device_reset);
  c_sleep: cover property (reset_out.pc_sp_clear && !reset_out.device_reset);
  c_cause: cover property (s_rd_cause);
endmodule : wdt_flags_asserts

bind watchdog_and_reset_flags wdt_flags_asserts #(.PORT_WIDTH(PORT_WIDTH)) u_asserts (
  .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .core_event(core_event), .reset_out(reset_out), .port_data(port_data), .port_dir(port_dir));

// ---- wdt_core_model.sv ----
// cpu core model: clear and halt instructions, sleep and wake
// assumes kick controls change at rising edges of clk_sys
`timescale 1ns/1ps
module wdt_core_model
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // periodic clear
  input wire logic kick_en,
  input wire logic [15:0] kick_gap,
  // block side
  input reset_out_type reset_out,
  output core_event_type core_event
);
  logic [15:0] gap = 16'h0;
  logic kick = 1'h0, clr = 1'h0, hlt = 1'h0, slp = 1'h0;

  assign core_event = '{clear_instr: kick | clr, halt_instr: hlt, sleep_idle: slp};

  // one clear (0) or halt (1) pulse; halt then sleeps
  task automatic pulse(input logic halt);
    @(posedge clk_sys);
    clr <= !halt;
    hlt <= halt;
    @(posedge clk_sys);
    clr <= 1'h0;
    hlt <= 1'h0;
    @(posedge clk_sys);
  endtask : pulse

  always @(posedge clk_sys)
  begin
    gap <= (kick_en && gap < kick_gap) ? gap + 16'h1 : 16'h0;
    kick <= kick_en && gap == kick_gap;
  end

  // any reset wakes the core; a halt puts it to sleep
  always @(posedge clk_sys)
    if (!rstn || reset_out.pc_sp_clear)
      slp <= 1'h0;
    else if (hlt)
      slp <= 1'h1;
endmodule : wdt_core_model

// ---- wdt_map.svh ----
// register map, field positions, reset values and timing figures
// assumes a 40 MHz system clock and 32-bit AHB-Lite data
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

`define ADDR_LSB_MSB 7
`define CTRL_ADDR 8'h00
`define CAUSE_ADDR 8'h04
`define STATUS_ADDR 8'h08

`define CTRL_RESET 8'h53
`define KEY_MSB 7
`define KEY_LSB 3
`define SEL_MSB 2
`define SEL_LSB 0
`define KEY_PATTERN_A 5'h0a
`define KEY_PATTERN_B 5'h15
`define PERIOD_EXP_0 8
`define PERIOD_EXP_1 10
`define PERIOD_EXP_2 12
`define PERIOD_EXP_3 14
`define PERIOD_EXP_4 15
`define PERIOD_EXP_5 16
`define PERIOD_EXP_6 17
`define PERIOD_EXP_7 18

`define KEY_FLAG_BIT 0
`define BROWN_FLAG_BIT 2
`define TIMEOUT_BIT 0
`define POWERDOWN_BIT 1
`define SLEEP_BIT 2
`define KEY_WAIT_BIT 3

`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0

`define CLK_MHZ 40
`define KEY_RESET_DELAY_NS 1000
`define BROWNOUT_QUALIFY_NS 120000
`define WDT_COUNT_WIDTH 18

`endif

// ---- wdt_pkg.sv ----
// types shared by the watchdog and reset-flag block
// assumes the map header supplies all numeric constants
package wdt_pkg;

  // strobes and levels from the cpu core, same clock
  typedef struct packed {
    logic clear_instr;
    logic halt_instr;
    logic sleep_idle;
  } core_event_type;

  // reset requests towards the core
  typedef struct packed {
    logic device_reset;
    logic pc_sp_clear;
  } reset_out_type;

  typedef enum logic [0:0] {
    KEY_OK = 1'b0,
    KEY_WAIT = 1'b1
  } key_state_type;

endpackage : wdt_pkg
